// ---- rtl/prs_pkg.sv ----
// package: constants, register map and types for the pci reset sequencer
package prs_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, 32-bit words)
  // ------------------------------------------------------------------
  localparam logic [7:0] PRS_ADDR_PSC_CTRL   = 8'h00;
  localparam logic [7:0] PRS_ADDR_STATUS     = 8'h04;
  localparam logic [7:0] PRS_ADDR_HOOK_BASE  = 8'h10;
  localparam logic [7:0] PRS_ADDR_LIVE_BASE  = 8'h20;
  localparam logic [7:0] PRS_ADDR_TGT_CTRL   = 8'h30;
  localparam logic [7:0] PRS_ADDR_CMD_STAT   = 8'h34;
  localparam logic [7:0] PRS_ADDR_ERR_INJ    = 8'h38;

  localparam int         PRS_NUM_HOOK        = 4;
  localparam logic [1:0] PRS_HOOK_IDX_LSB    = 2'h2;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PRS_PSC_RELEASE_BIT = 0;   // psc control: 1 = release
  localparam int PRS_PSC_ASSERT_BIT  = 1;   // psc control: 1 = re-assert
  localparam int PRS_ST_INT_RST      = 0;
  localparam int PRS_ST_EXT_RST      = 1;
  localparam int PRS_ST_DONE         = 2;
  localparam int PRS_ST_CONFIGURED   = 3;
  localparam int PRS_CS_MEMORY_SPACE_ENABLE_BIT   = 1;   // memory_space_enable
  localparam int PRS_CS_BUS_MASTER_ENABLE_BIT   = 2;   // bus_master_enable
  localparam int PRS_TW_WIDTH        = 6;   // target_window_enable 5..0
  localparam int PRS_CS_ERR_LSB      = 24;
  localparam int PRS_CS_ERR_W        = 8;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] PRS_HOOK_RESET     = 32'h0000_0000;
  localparam logic [31:0] PRS_CMD_STAT_RESET = 32'h0000_0000;
  localparam logic [5:0]  PRS_TGT_CTRL_RESET = 6'h00;
  localparam logic [31:0] PRS_CS_ERR_MASK    = 32'hFF00_0000;
  localparam logic [31:0] PRS_CS_CTRL_MASK   = 32'h00FF_FFFF;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } prs_bus_req_t;

  typedef enum logic [2:0] {
    PRS_ST_HELD    = 3'b001,
    PRS_ST_RUN     = 3'b010,
    PRS_ST_WAITEXT = 3'b100
  } prs_state_t;

endpackage

// ---- rtl/prs_pci_reset_seq.sv ----
// module: reset combination, sequencing and hook latching of the pci block
`timescale 1ns/1ps

// Overview of operation
// - external reset = bus reset pin or power-on
// - bus reset puts interface logic in defined state
// - controller asserts internal reset after global reset
// - power-on holds internal reset until software release
// - straps captured when power-on or warm releases
// - pci outputs tri-stated while in reset
// - no bus response until reconfigured
// - bus reset copies hooks into live registers
// - software writes hooks, effective next reset
// - error flags write-one-clear, never set by write
module prs_pci_reset_seq
  import prs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        bus_reset_pin_n,
  input  wire logic        por_n,
  input  wire logic        warm_reset_n,
  input  wire logic        global_reset_req,
  input  wire logic [7:0]  boot_cfg_pins,
  input  wire logic [7:0]  err_events,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             module_rst_n,
  output logic             reset_done_output,
  output logic             pci_out_en,
  output logic             bus_respond_en,
  output logic      [7:0]  boot_cfg_latched,
  output logic      [5:0]  target_window_enable,
  output logic             bus_master_enable,
  output logic             memory_space_enable
);

  // ------------------------------------------------------------------
  // reset combination and synchronisers
  // ------------------------------------------------------------------
  prs_bus_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  wire ext_rst_raw = ~bus_reset_pin_n | ~por_n;
  wire glb_rst_raw = ~warm_reset_n | ~por_n | global_reset_req;

  logic [1:0] ext_sync_reg;
  logic [1:0] glb_sync_reg;
  logic [1:0] por_sync_reg;
  logic [1:0] straps_sync_reg;
  logic       ext_rst;
  logic       glb_rst;
  logic       por_rst;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_sync_reg <= 2'h3;
      glb_sync_reg <= 2'h3;
      por_sync_reg <= 2'h3;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], ext_rst_raw};
      glb_sync_reg <= {glb_sync_reg[0], glb_rst_raw};
      por_sync_reg <= {por_sync_reg[0], ~por_n};
    end
  end
  assign ext_rst = ext_sync_reg[1];
  assign glb_rst = glb_sync_reg[1];
  assign por_rst = por_sync_reg[1];

  // ------------------------------------------------------------------
  // internal reset held by the power and sleep controller
  // ------------------------------------------------------------------
  prs_state_t state_reg;
  prs_state_t state_next;
  logic       ext_seen_reg;
  logic       int_rst;

  wire sel_psc   = req.wr && (req.addr == PRS_ADDR_PSC_CTRL);
  wire psc_rel   = sel_psc && req.wdata[PRS_PSC_RELEASE_BIT];
  wire psc_asrt  = sel_psc && req.wdata[PRS_PSC_ASSERT_BIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PRS_ST_HELD: begin
        // release waits for a bus reset, so halves never run split
        if (psc_rel && (ext_seen_reg || ext_rst))
          state_next = PRS_ST_RUN;
        else if (psc_rel)
          state_next = PRS_ST_WAITEXT;
      end
      PRS_ST_WAITEXT: begin
        if (ext_rst)
          state_next = PRS_ST_RUN;
      end
      PRS_ST_RUN: begin
        if (psc_asrt)
          state_next = PRS_ST_HELD;
      end
      default: state_next = PRS_ST_HELD;
    endcase
    if (glb_rst)
      state_next = PRS_ST_HELD;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= PRS_ST_HELD;
      ext_seen_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      if (glb_rst)
        ext_seen_reg <= ext_rst;
      else if (ext_rst)
        ext_seen_reg <= 1'b1;
    end
  end

  assign int_rst      = (state_reg != PRS_ST_RUN);
  assign module_rst_n = ~(int_rst | ext_rst);
  assign pci_out_en   = module_rst_n;

  // ------------------------------------------------------------------
  // strap capture on power-on or warm release
  // ------------------------------------------------------------------
  logic glb_pin_d_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      glb_pin_d_reg    <= 1'b1;
      boot_cfg_latched <= 8'h00;
    end else begin
      glb_pin_d_reg <= straps_sync_reg[1];
      if (glb_pin_d_reg && !straps_sync_reg[1])
        boot_cfg_latched <= boot_cfg_pins;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      straps_sync_reg <= 2'h3;
    else
      straps_sync_reg <= {straps_sync_reg[0], ~warm_reset_n | ~por_n};
  end

  // ------------------------------------------------------------------
  // hook and live registers
  // ------------------------------------------------------------------
  logic [31:0] hook_reg [PRS_NUM_HOOK];
  logic [31:0] live_reg [PRS_NUM_HOOK];
  logic [5:0]  tgt_ctrl_reg;
  logic [31:0] cmd_stat_reg;
  logic        configured_reg;

  function automatic logic in_bank(input logic [7:0] a,
                                   input logic [7:0] base);
    in_bank = (a[7:4] == base[7:4]);
  endfunction

  wire [1:0] widx     = req.addr[PRS_HOOK_IDX_LSB +: 2];
  wire       wr_hook  = req.wr && in_bank(req.addr, PRS_ADDR_HOOK_BASE);
  wire       wr_tgt   = req.wr && (req.addr == PRS_ADDR_TGT_CTRL);
  wire       wr_cs    = req.wr && (req.addr == PRS_ADDR_CMD_STAT);
  wire [31:0] err_set = {err_events, 24'h000000};
  wire [31:0] w1c     = wr_cs ? (req.wdata & PRS_CS_ERR_MASK) : 32'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < PRS_NUM_HOOK; i++)
        hook_reg[i] <= PRS_HOOK_RESET;
    end else if (wr_hook) begin
      hook_reg[widx] <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < PRS_NUM_HOOK; i++)
        live_reg[i] <= PRS_HOOK_RESET;
      tgt_ctrl_reg   <= PRS_TGT_CTRL_RESET;
      cmd_stat_reg   <= PRS_CMD_STAT_RESET;
      configured_reg <= 1'b0;
    end else if (ext_rst) begin
      for (int i = 0; i < PRS_NUM_HOOK; i++)
        live_reg[i] <= hook_reg[i];
      tgt_ctrl_reg   <= PRS_TGT_CTRL_RESET;
      cmd_stat_reg   <= PRS_CMD_STAT_RESET;
      configured_reg <= 1'b0;
    end else begin
      if (wr_tgt)
        tgt_ctrl_reg <= req.wdata[PRS_TW_WIDTH-1:0];
      // set wins over clear; writes never set a flag
      cmd_stat_reg <= ((cmd_stat_reg & ~w1c) | err_set) & PRS_CS_ERR_MASK
                    | (wr_cs ? (req.wdata & PRS_CS_CTRL_MASK)
                             : (cmd_stat_reg & PRS_CS_CTRL_MASK));
      if ((wr_tgt || wr_cs) && module_rst_n)
        configured_reg <= 1'b1;
    end
  end

  assign target_window_enable = tgt_ctrl_reg;
  assign bus_master_enable    = cmd_stat_reg[PRS_CS_BUS_MASTER_ENABLE_BIT];
  assign memory_space_enable  = cmd_stat_reg[PRS_CS_MEMORY_SPACE_ENABLE_BIT];
  assign bus_respond_en       = module_rst_n & configured_reg;
  assign reset_done_output    = module_rst_n;

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  wire [31:0] status_word = {28'h0, configured_reg, reset_done_output,
                             ext_rst, int_rst};
  always_comb begin
    rd_mux = 32'h0;
    if (in_bank(req.addr, PRS_ADDR_HOOK_BASE))
      rd_mux = hook_reg[widx];
    else if (in_bank(req.addr, PRS_ADDR_LIVE_BASE))
      rd_mux = live_reg[widx];
    else if (req.addr == PRS_ADDR_STATUS)
      rd_mux = status_word;
    else if (req.addr == PRS_ADDR_TGT_CTRL)
      rd_mux = {26'h0, tgt_ctrl_reg};
    else if (req.addr == PRS_ADDR_CMD_STAT)
      rd_mux = cmd_stat_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      rdata <= 32'h0;
    else
      rdata <= req.rd ? rd_mux : 32'h0;
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_ext_combine: assert property (@(posedge clk) disable iff (!resetn)
    ext_rst_raw |-> ##2 ext_rst) else $error("ext reset missed");
  chk_rst_gate: assert property (@(posedge clk) disable iff (!resetn)
    (int_rst || ext_rst) |-> !module_rst_n)
    else $error("module out of reset early");
  chk_tristate: assert property (@(posedge clk) disable iff (!resetn)
    !module_rst_n |-> !pci_out_en) else $error("pins driven");
  chk_glb_hold: assert property (@(posedge clk) disable iff (!resetn)
    glb_rst |=> int_rst) else $error("internal reset not held");
  chk_por_hold: assert property (@(posedge clk) disable iff (!resetn)
    (por_rst && !sel_psc) |=> int_rst) else $error("por release");
  chk_hook_copy: assert property (@(posedge clk) disable iff (!resetn)
    ext_rst |=> live_reg[0] == $past(hook_reg[0]))
    else $error("hook not copied");
  chk_no_resp: assert property (@(posedge clk) disable iff (!resetn)
    ext_rst |=> !bus_respond_en) else $error("responds early");
  chk_w1c_noset: assert property (@(posedge clk) disable iff (!resetn)
    (!ext_rst && err_events == 8'h00)
    |=> (cmd_stat_reg & PRS_CS_ERR_MASK & ~$past(cmd_stat_reg)) == 32'h0)
    else $error("flag set by write");
  chk_straps: assert property (@(posedge clk) disable iff (!resetn)
    (glb_pin_d_reg && !straps_sync_reg[1])
    |=> boot_cfg_latched == $past(boot_cfg_pins))
    else $error("straps missed");
  chk_defined: assert property (@(posedge clk) disable iff (!resetn)
    ext_rst |=> (tgt_ctrl_reg == PRS_TGT_CTRL_RESET))
    else $error("state not defined");

endmodule

// ---- sim/prs_board_model.sv ----
// board reset source: warm, bus and power-on reset pins
`timescale 1ns/1ps
module prs_board_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic with_por,
  output logic      bus_reset_pin_n,
  output logic      warm_reset_n,
  output logic      por_n
);
  logic [2:0] cnt_reg = 3'h0;
  logic       por_reg = 1'b0;
  // -----------------------------------------------------------------
  // one source for warm and bus reset, so they can never split
  // -----------------------------------------------------------------
  assign bus_reset_pin_n = (cnt_reg == 3'h0);
  assign warm_reset_n    = (cnt_reg == 3'h0);
  assign por_n           = !(por_reg && cnt_reg != 3'h0);
  always @(posedge clk) begin
    if (go && cnt_reg == 3'h0) begin
      cnt_reg <= 3'h6;
      por_reg <= with_por;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the pci reset sequencer
`timescale 1ns/1ps
module testbench
  import prs_pkg::*;
;
  // -----------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------
  logic clk = 1'b0, resetn = 1'b0, go = 1'b0, with_por = 1'b0;
  logic wr = 1'b0, rd = 1'b0, bus_reset_pin_n, por_n, warm_reset_n;
  logic glb_req = 1'b0;
  logic [7:0]  addr = 8'h00, boot_cfg_pins = 8'h00, err_events = 8'h00;
  logic [7:0]  boot_cfg_latched;
  logic [31:0] wdata = 32'h0, rdata;
  logic [5:0]  target_window_enable;
  logic module_rst_n, reset_done_output, pci_out_en, bus_respond_en;
  logic bus_master_enable, memory_space_enable;
  int   fails = 0, checked = 0, cycles = 0;
  always #25 clk = ~clk;
  prs_board_model board_u (.clk(clk), .go(go), .with_por(with_por),
    .bus_reset_pin_n(bus_reset_pin_n), .warm_reset_n(warm_reset_n),
    .por_n(por_n));
  // global request only as an emulation reset, never a watchdog one
  prs_pci_reset_seq dut_u (.clk(clk), .resetn(resetn),
    .bus_reset_pin_n(bus_reset_pin_n), .por_n(por_n),
    .warm_reset_n(warm_reset_n), .global_reset_req(glb_req),
    .boot_cfg_pins(boot_cfg_pins), .err_events(err_events),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .module_rst_n(module_rst_n), .reset_done_output(reset_done_output),
    .pci_out_en(pci_out_en), .bus_respond_en(bus_respond_en),
    .boot_cfg_latched(boot_cfg_latched),
    .target_window_enable(target_window_enable),
    .bus_master_enable(bus_master_enable),
    .memory_space_enable(memory_space_enable));
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse(input logic por);
    @(posedge clk);
    go <= 1'b1;
    with_por <= por;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({pci_out_en, module_rst_n}, 32'h0);
    repeat (8) @(posedge clk);
  endtask
  // bounded wait for the module to leave reset after a release write
  task automatic release_mod;
    int n;
    n = 0;
    // only the release bit: software never puts the module back
    wreg(PRS_ADDR_PSC_CTRL, 32'h1);
    while (module_rst_n !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    #1 chk({reset_done_output, module_rst_n, pci_out_en}, 32'h7);
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_power_up;
    chk({module_rst_n, pci_out_en}, 32'h0);
    rchk(PRS_ADDR_STATUS, 32'h1);
  endtask
  task automatic t_first_reset;
    @(posedge clk);
    boot_cfg_pins <= 8'h5A;
    wreg(PRS_ADDR_HOOK_BASE, 32'h1234_ABCD);
    pulse(1'b1);
    rchk(PRS_ADDR_LIVE_BASE, 32'h1234_ABCD);
    chk(boot_cfg_latched, 32'h5A);
    release_mod();
    chk(bus_respond_en, 32'h0);
  endtask
  task automatic t_configure;
    wreg(PRS_ADDR_TGT_CTRL, 32'h3F);
    wreg(PRS_ADDR_CMD_STAT, 32'h6);
    #1 chk({bus_respond_en, target_window_enable}, 32'h7F);
    chk({bus_master_enable, memory_space_enable}, 32'h3);
    rchk(PRS_ADDR_ERR_INJ, 32'h0);
  endtask
  task automatic t_err_flags;
    @(posedge clk);
    err_events <= 8'h81;
    @(posedge clk);
    err_events <= 8'h00;
    rchk(PRS_ADDR_CMD_STAT, 32'h8100_0006);
    wreg(PRS_ADDR_CMD_STAT, 32'h8000_0006);
    rchk(PRS_ADDR_CMD_STAT, 32'h0100_0006);
    wreg(PRS_ADDR_CMD_STAT, 32'h7F00_0006);
    rchk(PRS_ADDR_CMD_STAT, 32'h0000_0006);
  endtask
  task automatic t_warm_reset;
    wreg(PRS_ADDR_HOOK_BASE, 32'h0F0F_C3C3);
    rchk(PRS_ADDR_LIVE_BASE, 32'h1234_ABCD);
    // disconnect sequence ahead of the reset
    wreg(PRS_ADDR_TGT_CTRL, 32'h0);
    wreg(PRS_ADDR_CMD_STAT, 32'h0);
    // a pending error flag must be wiped by the bus reset
    @(posedge clk);
    err_events <= 8'h10;
    @(posedge clk);
    err_events <= 8'h00;
    rchk(PRS_ADDR_CMD_STAT, 32'h1000_0000);
    @(posedge clk);
    boot_cfg_pins <= 8'hC3;
    pulse(1'b0);
    chk(target_window_enable, 32'h0);
    rchk(PRS_ADDR_CMD_STAT, 32'h0);
    chk(module_rst_n, 32'h0);
    rchk(PRS_ADDR_LIVE_BASE, 32'h0F0F_C3C3);
    chk(boot_cfg_latched, 32'hC3);
    release_mod();
    chk(bus_respond_en, 32'h0);
  endtask
  // emulation reset: internal half only, a bus reset follows it
  task automatic t_emu_reset;
    @(posedge clk);
    glb_req <= 1'b1;
    repeat (3) @(posedge clk);
    glb_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(module_rst_n, 32'h0);
    rchk(PRS_ADDR_STATUS, 32'h1);
    // early release must be deferred until a bus reset is seen
    wreg(PRS_ADDR_PSC_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(module_rst_n, 32'h0);
    pulse(1'b0);
    release_mod();
  endtask
  // -----------------------------------------------------------------
  // verdict, hang guard and main sequence
  // -----------------------------------------------------------------
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 t_power_up();
    t_first_reset();
    t_configure();
    t_err_flags();
    t_warm_reset();
    t_emu_reset();
    results();
  end
endmodule
